// ### rtl/lsr_pkg.sv
// Constants, types and helper functions for the light sensor register set.
//
// Contract
// RL1 - Answer only to fixed address 1000100.
// RL2 - Compare first seven bits, eighth is direction.
// RL3 - Master owns clock; data driven by either.
// RL4 - Master opens with start, then address byte.
// RL5 - Master closes every transaction with stop.
// RL6 - Receiver pulls data low during acknowledge.
// RL7 - Command and control hold until rewritten.
// RL8 - Command bit 7 releases converter from reset.
// RL9 - Command bit 6 selects power-down.
// RL10 - Command bit 5 selects external integration timing.
// RL11 - Command bits 3:2 select diode source.
// RL12 - Command bits 1:0 set integration cycles.
// RL13 - Host writes zero to control bits 7,6,4.
// RL14 - Control bit 5 reads interrupt triggered.
// RL15 - Control bits 3:2 select lux range.
// RL16 - Control bits 1:0 set interrupt persistence.
// RL17 - Offset 02 upper threshold, resets to FF.
// RL18 - Offset 03 lower threshold, resets to 00.
// RL19 - Offsets 04,05 return latest result bytes.
// RL20 - Offsets 06,07 return integration cycle count.
// RL21 - Address bit 7 restarts integration, external mode.
// RL22 - Address bit 6 clears pending interrupt.
// RL23 - Interrupt pin active low, open drain.
// RL24 - External period spans two resync commands.
// RL25 - Pointer byte first, then write or read.
// RL26 - Writes to data registers acked, ignored.
package lsr_pkg;

  // ==========================================================================
  // Bus address and register offsets
  localparam logic [6:0] DEV_ADDR       = 7'h44;
  localparam logic [2:0] OFS_COMMAND    = 3'h0;
  localparam logic [2:0] OFS_CONTROL    = 3'h1;
  localparam logic [2:0] OFS_THR_HI     = 3'h2;
  localparam logic [2:0] OFS_THR_LO     = 3'h3;
  localparam logic [2:0] OFS_RESULT_LO  = 3'h4;
  localparam logic [2:0] OFS_RESULT_HI  = 3'h5;
  localparam logic [2:0] OFS_CYCLES_LO  = 3'h6;
  localparam logic [2:0] OFS_CYCLES_HI  = 3'h7;

  // ==========================================================================
  // Field positions
  localparam int CMD_ENABLE_BIT   = 7;
  localparam int CMD_PD_BIT       = 6;
  localparam int CMD_EXT_BIT      = 5;
  localparam int CMD_DIODE_LSB    = 2;
  localparam int CMD_WIDTH_LSB    = 0;
  localparam int CTL_FLAG_BIT     = 5;
  localparam int CTL_RANGE_LSB    = 2;
  localparam int CTL_PERSIST_LSB  = 0;
  localparam int PTR_RESYNC_BIT   = 7;
  localparam int PTR_CLEAR_BIT    = 6;

  // ==========================================================================
  // Reset values and codes
  localparam logic [7:0]  CMD_RESET        = 8'h00;
  localparam logic [3:0]  CTL_RESET        = 4'h0;
  localparam logic [7:0]  THR_HI_RESET     = 8'hFF;
  localparam logic [7:0]  THR_LO_RESET     = 8'h00;
  localparam logic [1:0]  DIODE_NOOP_CODE  = 2'h3;
  localparam logic [16:0] INTEG_CYC_RESET  = 17'h1_0000;

  // ==========================================================================
  // Bus engine states
  typedef enum logic [8:0]
  {
    ST_IDLE       = 9'h001,
    ST_ADDR       = 9'h002,
    ST_ADDR_ACK   = 9'h004,
    ST_PTR        = 9'h008,
    ST_PTR_ACK    = 9'h010,
    ST_WDATA      = 9'h020,
    ST_WDATA_ACK  = 9'h040,
    ST_RDATA      = 9'h080,
    ST_RDATA_ACK  = 9'h100
  } lsr_state_e;

  // ==========================================================================
  // Helpers
  function automatic logic [16:0] width_cycles(input logic [1:0] sel);
    case (sel)
      2'h0:    width_cycles = 17'h1_0000;
      2'h1:    width_cycles = 17'h0_1000;
      2'h2:    width_cycles = 17'h0_0100;
      default: width_cycles = 17'h0_0010;
    endcase
  endfunction

  function automatic logic [4:0] persist_need(input logic [1:0] sel);
    case (sel)
      2'h0:    persist_need = 5'h01;
      2'h1:    persist_need = 5'h04;
      2'h2:    persist_need = 5'h08;
      default: persist_need = 5'h10;
    endcase
  endfunction

  function automatic logic reg_mapped(input logic [5:0] ptr);
    reg_mapped = (ptr[5:3] == 3'h0);
  endfunction

endpackage

// ### rtl/lsr_alarm.sv
// Threshold window check with persistence count and sticky alarm flag.
`timescale 1ns/10ps
`default_nettype none
module lsr_alarm
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Conversion results
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample,
  // Configuration
  input  wire logic [7:0]  thr_hi,
  input  wire logic [7:0]  thr_lo,
  input  wire logic [1:0]  persist_sel,
  // Software clear
  input  wire logic        clear,
  // Flag
  output logic             flag
);

  logic [4:0] cnt;
  logic [4:0] need;
  logic       out_of_window;
  logic       hit;

  // =========================================================================
  // Window and persistence
  // The threshold low bytes are always zero, so only the upper bytes are held.
  assign out_of_window = (sample > {thr_hi, 8'h00}) || (sample < {thr_lo, 8'h00});
  assign need          = lsr_pkg::persist_need(persist_sel);
  assign hit           = sample_valid && out_of_window && (5'(cnt + 5'h01) >= need); // RL16

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt <= 5'h00;
    else if (sample_valid)
    begin
      if (!out_of_window)
        cnt <= 5'h00; // RL16
      else if (cnt < need)
        cnt <= 5'(cnt + 5'h01); // RL16
    end
  end

  // =========================================================================
  // Sticky flag
  // A trigger in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge clk)
  begin
    if (rst)
      flag <= 1'b0;
    else if (hit)
      flag <= 1'b1; // RL14
    else if (clear)
      flag <= 1'b0; // RL22
  end

endmodule
`default_nettype wire

// ### rtl/lsr_top.sv
// Two-wire slave, register set and converter control of the light sensor.
`timescale 1ns/10ps
`default_nettype none
module lsr_top
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // Serial bus
  input  wire logic        SCL_I,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE_N,
  // Interrupt pin
  output logic             INT_O,
  output logic             INT_OE_N,
  // Converter results
  input  wire logic        RESULT_VALID,
  input  wire logic [15:0] RESULT_DATA,
  input  wire logic [15:0] CYCLE_COUNT,
  // Converter control
  output logic             ADC_RESET,
  output logic             POWER_DOWN,
  output logic             EXT_TIMING,
  output logic [1:0]       DIODE_SEL,
  output logic             DIODE_NOOP,
  output logic [1:0]       RANGE_SEL,
  output logic [16:0]      INTEG_CYCLES,
  output logic             INTEG_RESTART
);

  lsr_pkg::lsr_state_e state;

  logic        scl_d;
  logic        scl_dd;
  logic        sda_d;
  logic        sda_dd;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;
  logic [3:0]  bit_cnt;
  logic [7:0]  rx;
  logic [7:0]  tx;
  logic        rw;
  logic [5:0]  ptr;
  logic        byte_done;
  logic        addr_match;
  logic        ptr_done;
  logic        data_done;
  logic [7:0]  rd_byte;
  logic [7:0]  cmd;
  logic [3:0]  ctl_cfg;
  logic [7:0]  thr_hi;
  logic [7:0]  thr_lo;
  logic [15:0] result;
  logic [15:0] cycles;
  logic        adc_live;
  logic        alarm_clear;
  logic        alarm_flag;

  // =========================================================================
  // Line sampling
  // The clock line is only ever observed; the device has no driver for it.
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      scl_d  <= 1'b1;
      scl_dd <= 1'b1;
      sda_d  <= 1'b1;
      sda_dd <= 1'b1;
    end
    else
    begin
      scl_d  <= SCL_I; // RL3
      scl_dd <= scl_d;
      sda_d  <= SDA_I;
      sda_dd <= sda_d;
    end
  end

  assign scl_rise   = scl_d && !scl_dd;
  assign scl_fall   = !scl_d && scl_dd;
  assign start_cond = scl_d && scl_dd && sda_dd && !sda_d; // RL4
  assign stop_cond  = scl_d && scl_dd && !sda_dd && sda_d; // RL5

  // =========================================================================
  // Byte decode
  assign byte_done  = scl_fall && (bit_cnt == 4'h8);
  assign addr_match = (rx[7:1] == lsr_pkg::DEV_ADDR); // RL1 RL2
  assign ptr_done   = (state == lsr_pkg::ST_PTR) && byte_done;
  assign data_done  = (state == lsr_pkg::ST_WDATA) && byte_done;
  assign adc_live   = cmd[lsr_pkg::CMD_ENABLE_BIT] && !cmd[lsr_pkg::CMD_PD_BIT];
  assign alarm_clear = ptr_done && rx[lsr_pkg::PTR_CLEAR_BIT]; // RL22

  // =========================================================================
  // Read data mux
  // Offsets outside the map read as zero rather than aliasing the set.
  always_comb
  begin
    rd_byte = 8'h00;
    if (lsr_pkg::reg_mapped(ptr))
    begin
      case (ptr[2:0])
        lsr_pkg::OFS_COMMAND:   rd_byte = cmd;
        lsr_pkg::OFS_CONTROL:   rd_byte = {2'b00, alarm_flag, 1'b0, ctl_cfg}; // RL14
        lsr_pkg::OFS_THR_HI:    rd_byte = thr_hi;
        lsr_pkg::OFS_THR_LO:    rd_byte = thr_lo;
        lsr_pkg::OFS_RESULT_LO: rd_byte = result[7:0]; // RL19
        lsr_pkg::OFS_RESULT_HI: rd_byte = result[15:8]; // RL19
        lsr_pkg::OFS_CYCLES_LO: rd_byte = cycles[7:0]; // RL20
        lsr_pkg::OFS_CYCLES_HI: rd_byte = cycles[15:8]; // RL20
        default:                rd_byte = 8'h00;
      endcase
    end
  end

  // =========================================================================
  // Bus engine
  // Data is changed only just after a clock fall, so the device never forms
  // a start or stop of its own while the clock is high.
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state    <= lsr_pkg::ST_IDLE;
      bit_cnt  <= 4'h0;
      rx       <= 8'h00;
      tx       <= 8'hFF;
      rw       <= 1'b0;
      ptr      <= 6'h00;
      SDA_OE_N <= 1'b1;
    end
    else if (start_cond)
    begin
      state    <= lsr_pkg::ST_ADDR; // RL4
      bit_cnt  <= 4'h0;
      SDA_OE_N <= 1'b1;
    end
    else if (stop_cond)
    begin
      state    <= lsr_pkg::ST_IDLE; // RL5
      bit_cnt  <= 4'h0;
      SDA_OE_N <= 1'b1;
    end
    else
    begin
      case (state)
        lsr_pkg::ST_IDLE:
        begin
          SDA_OE_N <= 1'b1;
        end
        lsr_pkg::ST_ADDR:
        begin
          if (scl_rise)
          begin
            rx      <= {rx[6:0], sda_d};
            bit_cnt <= 4'(bit_cnt + 4'h1);
          end
          else if (byte_done)
          begin
            bit_cnt <= 4'h0;
            if (addr_match)
            begin
              rw       <= rx[0]; // RL2
              SDA_OE_N <= 1'b0; // RL6
              state    <= lsr_pkg::ST_ADDR_ACK;
            end
            else
              state <= lsr_pkg::ST_IDLE; // RL1
          end
        end
        lsr_pkg::ST_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            if (rw)
            begin
              SDA_OE_N <= rd_byte[7]; // RL3
              tx       <= {rd_byte[6:0], 1'b1};
              bit_cnt  <= 4'h1;
              ptr      <= 6'(ptr + 6'h01);
              state    <= lsr_pkg::ST_RDATA; // RL25
            end
            else
            begin
              SDA_OE_N <= 1'b1;
              bit_cnt  <= 4'h0;
              state    <= lsr_pkg::ST_PTR; // RL25
            end
          end
        end
        lsr_pkg::ST_PTR:
        begin
          if (scl_rise)
          begin
            rx      <= {rx[6:0], sda_d};
            bit_cnt <= 4'(bit_cnt + 4'h1);
          end
          else if (byte_done)
          begin
            bit_cnt  <= 4'h0;
            ptr      <= rx[5:0]; // RL25
            SDA_OE_N <= 1'b0; // RL6
            state    <= lsr_pkg::ST_PTR_ACK;
          end
        end
        lsr_pkg::ST_PTR_ACK:
        begin
          if (scl_fall)
          begin
            SDA_OE_N <= 1'b1;
            bit_cnt  <= 4'h0;
            state    <= lsr_pkg::ST_WDATA;
          end
        end
        lsr_pkg::ST_WDATA:
        begin
          if (scl_rise)
          begin
            rx      <= {rx[6:0], sda_d};
            bit_cnt <= 4'(bit_cnt + 4'h1);
          end
          else if (byte_done)
          begin
            bit_cnt  <= 4'h0;
            ptr      <= 6'(ptr + 6'h01);
            SDA_OE_N <= 1'b0; // RL6 RL26
            state    <= lsr_pkg::ST_WDATA_ACK;
          end
        end
        lsr_pkg::ST_WDATA_ACK:
        begin
          if (scl_fall)
          begin
            SDA_OE_N <= 1'b1;
            bit_cnt  <= 4'h0;
            state    <= lsr_pkg::ST_WDATA;
          end
        end
        lsr_pkg::ST_RDATA:
        begin
          if (scl_fall)
          begin
            if (bit_cnt == 4'h8)
            begin
              SDA_OE_N <= 1'b1; // RL6
              bit_cnt  <= 4'h0;
              state    <= lsr_pkg::ST_RDATA_ACK;
            end
            else
            begin
              SDA_OE_N <= tx[7]; // RL3
              tx       <= {tx[6:0], 1'b1};
              bit_cnt  <= 4'(bit_cnt + 4'h1);
            end
          end
        end
        lsr_pkg::ST_RDATA_ACK:
        begin
          if (scl_rise && sda_d)
            state <= lsr_pkg::ST_IDLE; // RL6
          else if (scl_fall)
          begin
            SDA_OE_N <= rd_byte[7];
            tx       <= {rd_byte[6:0], 1'b1};
            bit_cnt  <= 4'h1;
            ptr      <= 6'(ptr + 6'h01);
            state    <= lsr_pkg::ST_RDATA;
          end
        end
        default:
        begin
          SDA_OE_N <= 1'b1;
          state    <= lsr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // The pin is open drain: the driven level is always low.
  always_ff @(posedge CLK)
  begin
    SDA_O <= 1'b0;
    INT_O <= 1'b0;
  end

  // =========================================================================
  // Configuration registers
  // Control reserved bits are not stored, so they read as zero whatever is sent.
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      cmd     <= lsr_pkg::CMD_RESET;
      ctl_cfg <= lsr_pkg::CTL_RESET;
      thr_hi  <= lsr_pkg::THR_HI_RESET; // RL17
      thr_lo  <= lsr_pkg::THR_LO_RESET; // RL18
    end
    else if (data_done && lsr_pkg::reg_mapped(ptr))
    begin
      case (ptr[2:0])
        lsr_pkg::OFS_COMMAND: cmd     <= rx; // RL7
        lsr_pkg::OFS_CONTROL: ctl_cfg <= rx[3:0]; // RL7 RL13
        lsr_pkg::OFS_THR_HI:  thr_hi  <= rx; // RL17
        lsr_pkg::OFS_THR_LO:  thr_lo  <= rx; // RL18
        default:              cmd     <= cmd; // RL26
      endcase
    end
  end

  // =========================================================================
  // Result capture
  // Results are dropped while the converter is held in reset or powered down.
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      result <= 16'h0000;
      cycles <= 16'h0000;
    end
    else if (RESULT_VALID && adc_live)
    begin
      result <= RESULT_DATA; // RL19
      cycles <= CYCLE_COUNT; // RL20
    end
  end

  // =========================================================================
  // Converter control outputs
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ADC_RESET    <= 1'b1;
      POWER_DOWN   <= 1'b0;
      EXT_TIMING   <= 1'b0;
      DIODE_SEL    <= 2'h0;
      DIODE_NOOP   <= 1'b0;
      RANGE_SEL    <= 2'h0;
      INTEG_CYCLES <= lsr_pkg::INTEG_CYC_RESET;
    end
    else
    begin
      ADC_RESET    <= !cmd[lsr_pkg::CMD_ENABLE_BIT]; // RL8
      POWER_DOWN   <= cmd[lsr_pkg::CMD_PD_BIT]; // RL9
      EXT_TIMING   <= cmd[lsr_pkg::CMD_EXT_BIT]; // RL10
      DIODE_SEL    <= cmd[lsr_pkg::CMD_DIODE_LSB +: 2]; // RL11
      DIODE_NOOP   <= (cmd[lsr_pkg::CMD_DIODE_LSB +: 2] == lsr_pkg::DIODE_NOOP_CODE); // RL11
      RANGE_SEL    <= ctl_cfg[lsr_pkg::CTL_RANGE_LSB +: 2]; // RL15
      INTEG_CYCLES <= lsr_pkg::width_cycles(cmd[lsr_pkg::CMD_WIDTH_LSB +: 2]); // RL12
    end
  end

  // A restart both closes one external period and opens the next.
  always_ff @(posedge CLK)
  begin
    if (RST)
      INTEG_RESTART <= 1'b0;
    else
      INTEG_RESTART <= ptr_done && rx[lsr_pkg::PTR_RESYNC_BIT]
                       && cmd[lsr_pkg::CMD_EXT_BIT]; // RL21 RL24
  end

  // =========================================================================
  // Interrupt
  lsr_alarm u_alarm
  (
    .clk          (CLK),
    .rst          (RST),
    .sample_valid (RESULT_VALID && adc_live),
    .sample       (RESULT_DATA),
    .thr_hi       (thr_hi),
    .thr_lo       (thr_lo),
    .persist_sel  (ctl_cfg[lsr_pkg::CTL_PERSIST_LSB +: 2]),
    .clear        (alarm_clear),
    .flag         (alarm_flag)
  );

  always_ff @(posedge CLK)
  begin
    if (RST)
      INT_OE_N <= 1'b1;
    else
      INT_OE_N <= !alarm_flag; // RL23
  end

endmodule
`default_nettype wire

// ### dv/lsr_checker.sv
// Port-level assertions for the light sensor register set.
`timescale 1ns/10ps
`default_nettype none
module lsr_checker
(
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST,
  // Serial bus
  input wire logic        SCL_I,
  input wire logic        SDA_I,
  input wire logic        SDA_O,
  input wire logic        SDA_OE_N,
  // Interrupt pin
  input wire logic        INT_O,
  input wire logic        INT_OE_N,
  // Converter results
  input wire logic        RESULT_VALID,
  input wire logic [15:0] RESULT_DATA,
  input wire logic [15:0] CYCLE_COUNT,
  // Converter control
  input wire logic        ADC_RESET,
  input wire logic        POWER_DOWN,
  input wire logic        EXT_TIMING,
  input wire logic [1:0]  DIODE_SEL,
  input wire logic        DIODE_NOOP,
  input wire logic [1:0]  RANGE_SEL,
  input wire logic [16:0] INTEG_CYCLES,
  input wire logic        INTEG_RESTART
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  property p_int_pin;
    INT_O == 1'b0;
  endproperty
  property p_sda_pin;
    SDA_O == 1'b0;
  endproperty
  // Data may only move while the master holds the clock low.
  property p_sda_edge;
    $changed(SDA_OE_N) |-> !SCL_I;
  endproperty
  property p_noop;
    DIODE_NOOP == (DIODE_SEL == 2'h3);
  endproperty
  property p_cycles;
    INTEG_CYCLES inside {17'h1_0000, 17'h0_1000, 17'h0_0100, 17'h0_0010};
  endproperty
  property p_cfg_hold;
    $changed({ADC_RESET, POWER_DOWN, EXT_TIMING, DIODE_SEL, RANGE_SEL, INTEG_CYCLES})
      |-> !SDA_OE_N;
  endproperty
  property p_restart;
    INTEG_RESTART |-> (EXT_TIMING && !SDA_OE_N) ##1 !INTEG_RESTART;
  endproperty
  property p_int_set;
    $fell(INT_OE_N) |-> $past(RESULT_VALID, 2);
  endproperty
  property p_int_clr;
    $rose(INT_OE_N) |-> !SDA_OE_N;
  endproperty

  // ==========================================================================
  // Assertions and covers
  a_int_pin: assert property (p_int_pin) else $error("interrupt pin driven high");
  a_sda_pin: assert property (p_sda_pin) else $error("data pin driven high");
  a_sda_edge: assert property (p_sda_edge) else $error("data moved with clock high");
  a_noop: assert property (p_noop) else $error("diode no-op decode wrong");
  a_cycles: assert property (p_cycles) else $error("integration cycles illegal");
  a_cfg_hold: assert property (p_cfg_hold) else $error("config moved without write");
  a_restart: assert property (p_restart) else $error("restart pulse wrong");
  a_int_set: assert property (p_int_set) else $error("interrupt without result");
  a_int_clr: assert property (p_int_clr) else $error("interrupt release untimed");
  c_restart: cover property (INTEG_RESTART);
  c_int: cover property ($fell(INT_OE_N));
  c_ack: cover property ($fell(SDA_OE_N));
endmodule

bind lsr_top lsr_checker chk_i
(
  .CLK(CLK), .RST(RST), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_N(SDA_OE_N),
  .INT_O(INT_O), .INT_OE_N(INT_OE_N), .RESULT_VALID(RESULT_VALID),
  .RESULT_DATA(RESULT_DATA), .CYCLE_COUNT(CYCLE_COUNT), .ADC_RESET(ADC_RESET),
  .POWER_DOWN(POWER_DOWN), .EXT_TIMING(EXT_TIMING), .DIODE_SEL(DIODE_SEL),
  .DIODE_NOOP(DIODE_NOOP), .RANGE_SEL(RANGE_SEL), .INTEG_CYCLES(INTEG_CYCLES),
  .INTEG_RESTART(INTEG_RESTART)
);
`default_nettype wire

// ### dv/lsr_host.sv
// Two-wire bus master model standing in for the host controller.
`timescale 1ns/10ps
`default_nettype none
module lsr_host
(
  // Clock
  input  wire logic clk,
  // Bus lines
  input  wire logic sda_in,
  output var  logic scl,
  output var  logic sda_drv,
  // Missing acknowledge seen
  output var  logic ack_bad
);
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
    ack_bad = 1'b0;
  end

  // Four clocks per phase; the slave needs at least two.
  task automatic tick();
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic ack_clr();
    ack_bad = 1'b0;
  endtask

  task automatic start_c();
    sda_drv = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_drv = 1'b0;
    tick();
    scl = 1'b0;
    tick();
  endtask

  task automatic stop_c();
    sda_drv = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda_drv = 1'b1;
    tick();
  endtask

  task automatic bit_c(input logic b, output logic s);
    sda_drv = b;
    tick();
    scl = 1'b1;
    tick();
    s = sda_in;
    scl = 1'b0;
    tick();
  endtask

  task automatic byte_tx(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_c(b[i], s);
    bit_c(1'b1, s);
    if (s)
      ack_bad = 1'b1;
  endtask

  task automatic byte_rx(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_c(1'b1, d[i]);
    bit_c(last, s);
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic n);
    start_c();
    byte_tx(8'h88);
    byte_tx(p);
    if (n)
      byte_tx(d);
    stop_c();
  endtask

  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    start_c();
    byte_tx(8'h88);
    byte_tx(p);
    start_c();
    byte_tx(8'h89);
    byte_rx(1'b1, d);
    stop_c();
  endtask
endmodule
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the light sensor two-wire register set.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rv = 1'b0;
  logic [15:0] rdat = 16'h0000;
  logic [15:0] cnt = 16'h0000;
  logic        scl, sda_drv, ack_bad, sda_o, sda_oe_n, int_o, int_oe_n;
  logic        adc_rst, pwr_dn, ext_t, noop, restart;
  logic [1:0]  dsel, rsel, k;
  logic [16:0] icyc;
  logic [7:0]  cmd;
  logic [7:0]  rst_tab [8] = '{8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  wire         sda_w;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          restarts = 0;

  // The data line has a pull-up; either side only pulls it low.
  assign sda_w = sda_drv & (sda_oe_n | sda_o);
  always #4 clk = ~clk;
  always @(posedge clk)
    if (restart === 1'b1)
      restarts++;

  lsr_top uut
  (
    .CLK(clk), .RST(rst), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n),
    .INT_O(int_o), .INT_OE_N(int_oe_n), .RESULT_VALID(rv), .RESULT_DATA(rdat),
    .CYCLE_COUNT(cnt), .ADC_RESET(adc_rst), .POWER_DOWN(pwr_dn), .EXT_TIMING(ext_t),
    .DIODE_SEL(dsel), .DIODE_NOOP(noop), .RANGE_SEL(rsel), .INTEG_CYCLES(icyc),
    .INTEG_RESTART(restart)
  );
  lsr_host host (.clk(clk), .sda_in(sda_w), .scl(scl), .sda_drv(sda_drv), .ack_bad(ack_bad));

  // ==========================================================================
  // Helpers
  task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rchk(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] d;
    host.rd(p, d);
    chk($sformatf("reg %h", p), 17'(e), 17'(d));
  endtask

  task automatic w2();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic res(input logic [15:0] d, input logic [15:0] c);
    rdat = d;
    cnt = c;
    rv = 1'b1;
    @(posedge clk);
    #1;
    rv = 1'b0;
    w2();
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    w2();
    rst_tab[0] = 8'h00;
    for (int i = 0; i < 8; i++)
      rchk(8'(i), rst_tab[i]);
    chk("adc_reset", 17'h0_0001, 17'(adc_rst));
    chk("integ_cycles", 17'h1_0000, icyc);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      k = 2'(i);
      cmd = {4'hA, k, k};
      host.wr(8'h00, cmd, 1'b1);
      chk("diode_sel", 17'(k), 17'(dsel));
      chk("diode_noop", 17'(k == 2'h3), 17'(noop));
      chk("integ_cycles", 17'h1_0000 >> (4 * i), icyc);
      chk("ext_timing", 17'h0_0001, 17'(ext_t));
      chk("adc_reset", 17'h0_0000, 17'(adc_rst));
      rchk(8'h00, cmd);
      host.wr(8'h01, {4'h0, k, k}, 1'b1);
      chk("range_sel", 17'(k), 17'(rsel));
      rchk(8'h01, {4'h0, k, k});
    end
    host.wr(8'h00, 8'h40, 1'b1);
    chk("power_down", 17'h0_0001, 17'(pwr_dn));
    chk("adc_reset", 17'h0_0001, 17'(adc_rst));
    res(16'hBEEF, 16'h1111);
    rchk(8'h04, 8'h00);
    $display("test config done");
    host.wr(8'h00, 8'h80, 1'b1);
    res(16'h1234, 16'h5678);
    rchk(8'h04, 8'h34);
    rchk(8'h05, 8'h12);
    rchk(8'h06, 8'h78);
    rchk(8'h07, 8'h56);
    host.wr(8'h04, 8'hAA, 1'b1);
    rchk(8'h04, 8'h34);
    rchk(8'h08, 8'h00);
    $display("test data done");
    host.wr(8'h02, 8'h10, 1'b1);
    host.wr(8'h01, 8'h01, 1'b1);
    rchk(8'h02, 8'h10);
    for (int i = 0; i < 3; i++)
    begin
      res(16'h2000, 16'h0010);
      chk("int_oe_n", 17'h0_0001, 17'(int_oe_n));
    end
    res(16'h2000, 16'h0010);
    chk("int_oe_n", 17'h0_0000, 17'(int_oe_n));
    chk("int_pin", 17'h0_0000, 17'(int_oe_n | int_o));
    rchk(8'h01, 8'h21);
    host.wr(8'h40, 8'h00, 1'b0);
    chk("int_oe_n", 17'h0_0001, 17'(int_oe_n));
    rchk(8'h01, 8'h01);
    $display("test alarm done");
    host.wr(8'h00, 8'hA0, 1'b1);
    restarts = 0;
    host.wr(8'h80, 8'h00, 1'b0);
    chk("restarts", 17'h0_0001, 17'(restarts));
    host.wr(8'h00, 8'h80, 1'b1);
    host.wr(8'hC0, 8'h00, 1'b0);
    chk("restarts", 17'h0_0001, 17'(restarts));
    $display("test resync done");
    chk("ack_bad", 17'h0_0000, 17'(ack_bad));
    host.start_c();
    host.byte_tx(8'h8A);
    host.stop_c();
    chk("ack_bad", 17'h0_0001, 17'(ack_bad));
    host.ack_clr();
    rchk(8'h00, 8'h80);
    $display("test address done");
    end_sim();
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire
